// ---- hdl/flc_core.sv ----
// Purpose: command, protection and status front end of an on-chip flash
// Assumes: one clock, array timing engine outside, inputs synchronous
// Notes: array writes arrive on arr_*, engine driven by eng_*
//
// Contract
// - key select steers key writes or commands
// - reset loads protection from nonvolatile byte
// - protection write may only shrink select
// - disable set: nothing protected, writes ignored
// - select gives end of unprotected region
// - protected block refuses program and erase
// - debug writes change protection freely
// - writing one to empty flag launches
// - only bursts queue; empty flag tracks buffer
// - complete flag follows idle, ignores writes
// - protected target sets violation, discards command
// - sequence, divider, stop errors set access error
// - one clears access error, zero ignored
// - blank result flag after blank check
// - blank flag clears on new launch
// - decode blank, byte, burst codes
// - decode page and mass erase
// - other codes raise access error
// - flash tick from bus clock and divisor
// - blank success opens security code
//
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "flc_map.svh"
module flc_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic arr_we,
  input wire logic [15:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  input wire logic [7:0] nonvolatile_protect_byte,
  input wire logic [1:0] nv_security_code,
  input wire logic bdm_prot_we,
  input wire logic [7:0] bdm_prot_wdata,
  input wire logic stop_req,
  input wire logic eng_done,
  input wire logic eng_blank,
  output logic eng_start,
  output logic eng_abort,
  output logic [7:0] eng_cmd,
  output logic [15:0] eng_addr,
  output logic [7:0] eng_data,
  output logic fclk_tick,
  output logic key_we,
  output logic [2:0] key_idx,
  output logic [7:0] key_data,
  output logic [1:0] security_state_code
);
  // ==========================================================
  // helpers
  function automatic logic cmd_legal(input logic [7:0] c);
    cmd_legal = (c == `FLC_CMD_BLANK) || (c == `FLC_CMD_BYTE) ||
      (c == `FLC_CMD_BURST) || (c == `FLC_CMD_PAGE) ||
      (c == `FLC_CMD_MASS);
  endfunction : cmd_legal

  function automatic logic cmd_pe(input logic [7:0] c);
    cmd_pe = cmd_legal(c) && (c != `FLC_CMD_BLANK);
  endfunction : cmd_pe

  // ==========================================================
  // state
  flc_pkg::flc_seq_t seq_r;
  logic [7:0] prot_r;
  logic [6:0] div_r;
  logic div_done_r;
  logic key_sel_r;
  logic [7:0] cmd_r;
  logic [15:0] addr_r;
  logic [7:0] data_r;
  logic cbef_r, ccf_r, pviol_r, accerr_r, blank_r;
  logic act_r, pend_r;
  logic [7:0] act_cmd_r, pend_cmd_r;
  logic [15:0] pend_addr_r;
  logic [7:0] pend_data_r;
  logic [2:0] pre_cnt_r;
  logic [5:0] div_cnt_r;
  logic [1:0] sec_r;

  // ==========================================================
  // decode
  logic wr_div, wr_cfg, wr_prot, wr_stat, wr_cmd;
  logic launch_req, arr_cmd, key_hit;
  assign wr_div = reg_we && (reg_addr == `FLC_OFS_DIV);
  assign wr_cfg = reg_we && (reg_addr == `FLC_OFS_CFG);
  assign wr_prot = reg_we && (reg_addr == `FLC_OFS_PROT);
  assign wr_stat = reg_we && (reg_addr == `FLC_OFS_STAT);
  assign wr_cmd = reg_we && (reg_addr == `FLC_OFS_CMD);
  assign launch_req = wr_stat && reg_wdata[`FLC_ST_CBEF];
  assign arr_cmd = arr_we && !key_sel_r;
  assign key_hit = arr_we && key_sel_r &&
    (arr_addr >= `FLC_KEY_LO) && (arr_addr <= `FLC_KEY_HI);

  // ==========================================================
  // launch checks
  logic pdis, act_burst, seq_err, go, bad_cmd, div_err, q_err;
  logic pv_hit, acc_set, pv_set, ok, stop_err, blank_ok;
  assign pdis = prot_r[`FLC_PROT_DIS];
  assign act_burst = act_r && (act_cmd_r == `FLC_CMD_BURST);
  // mass erase touches the protected block whenever protection is on
  assign pv_hit = cmd_pe(cmd_r) && !pdis &&
    ((cmd_r == `FLC_CMD_MASS) ||
     (addr_r[15:`FLC_PAGE_LSB] > prot_r[7:1]));
  assign seq_err = (arr_cmd && ((seq_r != flc_pkg::FLC_IDLE) || !cbef_r)) ||
    (wr_cmd && (seq_r != flc_pkg::FLC_ADDR)) ||
    (launch_req && ((seq_r != flc_pkg::FLC_CMD) || !cbef_r));
  assign go = launch_req && (seq_r == flc_pkg::FLC_CMD) && cbef_r;
  assign bad_cmd = !cmd_legal(cmd_r);
  assign div_err = cmd_pe(cmd_r) && !div_done_r;
  // only a burst may wait behind a running burst
  assign q_err = act_r && !(act_burst && (cmd_r == `FLC_CMD_BURST));
  assign stop_err = stop_req && (act_r || pend_r);
  assign acc_set = seq_err || stop_err ||
    (go && (bad_cmd || div_err || q_err));
  assign pv_set = go && !bad_cmd && !div_err && !q_err && pv_hit;
  assign ok = go && !bad_cmd && !div_err && !q_err && !pv_hit;
  assign blank_ok = eng_done && act_r && (act_cmd_r == `FLC_CMD_BLANK) &&
    eng_blank;

  // ==========================================================
  // command sequence
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      seq_r <= flc_pkg::FLC_IDLE;
      cmd_r <= `FLC_RST_CMD;
      addr_r <= 16'h0000;
      data_r <= 8'h00;
    end else begin
      if (seq_err || go) begin
        seq_r <= flc_pkg::FLC_IDLE;
      end else if (arr_cmd) begin
        seq_r <= flc_pkg::FLC_ADDR;
        addr_r <= arr_addr;
        data_r <= arr_wdata;
      end else if (wr_cmd) begin
        seq_r <= flc_pkg::FLC_CMD;
      end
      if (wr_cmd) begin
        cmd_r <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // engine hand-off and burst queue
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      act_r <= 1'b0;
      pend_r <= 1'b0;
      act_cmd_r <= 8'h00;
      pend_cmd_r <= 8'h00;
      pend_addr_r <= 16'h0000;
      pend_data_r <= 8'h00;
      eng_start <= 1'b0;
      eng_abort <= 1'b0;
      eng_cmd <= 8'h00;
      eng_addr <= 16'h0000;
      eng_data <= 8'h00;
    end else begin
      eng_start <= 1'b0;
      eng_abort <= 1'b0;
      if (stop_err) begin
        act_r <= 1'b0;
        pend_r <= 1'b0;
        eng_abort <= 1'b1;
      end else if (eng_done && act_r && pend_r) begin
        pend_r <= 1'b0;
        act_cmd_r <= pend_cmd_r;
        eng_start <= 1'b1;
        eng_cmd <= pend_cmd_r;
        eng_addr <= pend_addr_r;
        eng_data <= pend_data_r;
      end else if (ok && (!act_r || eng_done)) begin
        act_r <= 1'b1;
        act_cmd_r <= cmd_r;
        eng_start <= 1'b1;
        eng_cmd <= cmd_r;
        eng_addr <= addr_r;
        eng_data <= data_r;
      end else if (ok) begin
        pend_r <= 1'b1;
        pend_cmd_r <= cmd_r;
        pend_addr_r <= addr_r;
        pend_data_r <= data_r;
      end else if (eng_done && act_r) begin
        act_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // status flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cbef_r <= 1'b1;
      ccf_r <= 1'b1;
    end else if (ok) begin
      cbef_r <= 1'b0;
      ccf_r <= 1'b0;
    end else begin
      // empty again once a burst sits in the engine with nothing queued
      cbef_r <= !pend_r && (!act_r || act_burst);
      ccf_r <= cbef_r && !act_r && !pend_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pviol_r <= 1'b0;
      accerr_r <= 1'b0;
    end else begin
      if (pv_set) begin
        pviol_r <= 1'b1;
      end else if (wr_stat && reg_wdata[`FLC_ST_PVIOL]) begin
        pviol_r <= 1'b0;
      end
      if (acc_set) begin
        accerr_r <= 1'b1;
      end else if (wr_stat && reg_wdata[`FLC_ST_ACCERR]) begin
        accerr_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blank_r <= 1'b0;
    end else if (blank_ok) begin
      blank_r <= 1'b1;
    end else if (ok) begin
      blank_r <= 1'b0;
    end
  end

  // ==========================================================
  // protection and security
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prot_r <= nonvolatile_protect_byte;
    end else if (bdm_prot_we) begin
      prot_r <= bdm_prot_wdata;
    end else if (wr_prot && !pdis && (reg_wdata[7:1] <= prot_r[7:1])) begin
      prot_r[7:1] <= reg_wdata[7:1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sec_r <= nv_security_code;
    end else if (blank_ok) begin
      sec_r <= `FLC_SEC_OPEN;
    end
  end

  // ==========================================================
  // configuration and clock divider
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_r <= `FLC_RST_DIV;
      div_done_r <= 1'b0;
      key_sel_r <= `FLC_RST_CFG;
    end else begin
      if (wr_div) begin
        div_r <= reg_wdata[6:0];
        div_done_r <= 1'b1;
      end
      if (wr_cfg) begin
        key_sel_r <= reg_wdata[`FLC_CFG_KEYSEL];
      end
    end
  end

  logic pre_tick;
  assign pre_tick = !div_r[`FLC_DIV_PRE8] || (pre_cnt_r == `FLC_PRE_LAST);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pre_cnt_r <= 3'h0;
      div_cnt_r <= 6'h00;
      fclk_tick <= 1'b0;
    end else begin
      fclk_tick <= 1'b0;
      if (wr_div) begin
        pre_cnt_r <= 3'h0;
        div_cnt_r <= 6'h00;
      end else if (div_done_r) begin
        pre_cnt_r <= pre_cnt_r + 3'h1;
        if (pre_tick) begin
          if (div_cnt_r == div_r[5:0]) begin
            div_cnt_r <= 6'h00;
            fclk_tick <= 1'b1;
          end else begin
            div_cnt_r <= div_cnt_r + 6'h01;
          end
        end
      end
    end
  end

  // ==========================================================
  // backdoor key writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      key_we <= 1'b0;
      key_idx <= 3'h0;
      key_data <= 8'h00;
    end else begin
      key_we <= key_hit;
      if (key_hit) begin
        key_idx <= arr_addr[2:0];
        key_data <= arr_wdata;
      end
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !reg_re) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        `FLC_OFS_DIV: reg_rdata <= {div_done_r, div_r};
        `FLC_OFS_CFG: reg_rdata <= {2'b00, key_sel_r, 5'h00};
        `FLC_OFS_PROT: reg_rdata <= prot_r;
        `FLC_OFS_STAT: reg_rdata <= {cbef_r, ccf_r, pviol_r, accerr_r,
          1'b0, blank_r, 2'b00};
        `FLC_OFS_CMD: reg_rdata <= cmd_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign security_state_code = sec_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  launch_clears_a: assert property (ok |=> !cbef_r && !ccf_r && (eng_start || pend_r))
    else $error("launch did not clear flags");
  bad_code_a: assert property (go && bad_cmd |=> accerr_r && !eng_start)
    else $error("illegal code not refused");
  no_divider_a: assert property (go && div_err |=> accerr_r)
    else $error("undivided program not refused");
  viol_set_a: assert property (pv_set |=> pviol_r && !eng_start)
    else $error("protected command not refused");
  acc_hold_a: assert property (accerr_r && wr_stat && !reg_wdata[4] |=> accerr_r)
    else $error("zero write cleared access error");
  prot_frozen_a: assert property (wr_prot && pdis && !bdm_prot_we |=> $stable(prot_r))
    else $error("protection changed while disabled");
  prot_grow_a: assert property (wr_prot && !bdm_prot_we |=>
    prot_r[7:1] <= $past(prot_r[7:1]))
    else $error("protection decreased");
  blank_pass_a: assert property (blank_ok |=> blank_r && sec_r == 2'h2)
    else $error("blank success not recorded");
  key_route_a: assert property (key_hit |=> key_we &&
    key_idx == $past(arr_addr[2:0]) && key_data == $past(arr_wdata))
    else $error("key write lost");
  key_no_cmd_a: assert property (arr_we && key_sel_r |=> seq_r == $past(seq_r))
    else $error("key write started a command");
  ccf_idle_a: assert property (act_r |=> !ccf_r)
    else $error("complete while active");

  burst_queue_c: cover property (ok && act_r ##1 pend_r);
  blank_pass_c: cover property (blank_ok);
  viol_c: cover property (pv_set);
  tick_c: cover property (fclk_tick && div_r[6]);
endmodule : flc_core
`default_nettype wire

// ---- hdl/flc_map.svh ----
// Purpose: register offsets, fields, codes and counts of the flash command front end
// Assumes: byte-wide register port
// Notes: definitions only
`ifndef FLC_MAP_SVH
`define FLC_MAP_SVH
// ==========================================================
// offsets
`define FLC_OFS_DIV 8'h00
`define FLC_OFS_CFG 8'h01
`define FLC_OFS_PROT 8'h02
`define FLC_OFS_STAT 8'h03
`define FLC_OFS_CMD 8'h04
// ==========================================================
// fields
`define FLC_ST_CBEF 7
`define FLC_ST_CCF 6
`define FLC_ST_PVIOL 5
`define FLC_ST_ACCERR 4
`define FLC_ST_BLANK 2
`define FLC_CFG_KEYSEL 5
`define FLC_DIV_DONE 7
`define FLC_DIV_PRE8 6
`define FLC_PROT_DIS 0
// ==========================================================
// command codes
`define FLC_CMD_BLANK 8'h05
`define FLC_CMD_BYTE 8'h20
`define FLC_CMD_BURST 8'h25
`define FLC_CMD_PAGE 8'h40
`define FLC_CMD_MASS 8'h41
// ==========================================================
// reset values, keys, counts
`define FLC_RST_DIV 7'h00
`define FLC_RST_CFG 1'b0
`define FLC_RST_CMD 8'h00
`define FLC_KEY_LO 16'hFFB0
`define FLC_KEY_HI 16'hFFB7
`define FLC_SEC_OPEN 2'h2
`define FLC_PRE_LAST 3'h7
`define FLC_PAGE_LSB 9
`endif

// ---- hdl/flc_pkg.sv ----
// Purpose: types of the flash command front end
// Assumes: nothing
// Notes: constants live in flc_map.svh
package flc_pkg;
  // ==========================================================
  // command sequence states
  typedef enum logic [1:0] {
    FLC_IDLE = 2'b00,
    FLC_ADDR = 2'b01,
    FLC_CMD = 2'b10
  } flc_seq_t;
endpackage : flc_pkg

// ---- test/tb_top.sv ----
// Purpose: self-checking bench of the flash command, protection and status front end
// Assumes: register port with one-cycle read data, engine answers driven by the bench
// Notes: stop entry, burst queueing and a second reset are driven by their own scenarios
`timescale 1ns/10ps
`default_nettype none
`include "flc_map.svh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic arr_we = 1'b0;
  logic [15:0] arr_addr = 16'h0000;
  logic [7:0] arr_wdata = 8'h00;
  logic bdm_prot_we = 1'b0;
  logic [7:0] bdm_prot_wdata = 8'h00;
  logic eng_done = 1'b0;
  logic eng_blank = 1'b0;
  logic stop_req = 1'b0;
  logic [7:0] nv_prot = 8'hF0;
  logic [1:0] nv_sec = 2'h3;
  logic eng_start, eng_abort, fclk_tick, key_we;
  logic [7:0] eng_cmd, eng_data, key_data;
  logic [15:0] eng_addr;
  logic [2:0] key_idx;
  logic [1:0] security_state_code;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 clk_sys = ~clk_sys;

  flc_core i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .arr_we(arr_we),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .nonvolatile_protect_byte(nv_prot),
    .nv_security_code(nv_sec), .bdm_prot_we(bdm_prot_we), .bdm_prot_wdata(bdm_prot_wdata),
    .stop_req(stop_req), .eng_done(eng_done), .eng_blank(eng_blank), .eng_start(eng_start),
    .eng_abort(eng_abort), .eng_cmd(eng_cmd), .eng_addr(eng_addr), .eng_data(eng_data),
    .fclk_tick(fclk_tick), .key_we(key_we), .key_idx(key_idx), .key_data(key_data),
    .security_state_code(security_state_code)
  );

  // ==========================================================
  // bus and compare helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) begin
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
    end
    @(posedge clk_sys) reg_we <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys) begin
      reg_re <= 1'b1;
      reg_addr <= a;
    end
    @(posedge clk_sys) reg_re <= 1'b0;
    #1 chk(reg_rdata, exp, what);
  endtask : rd_chk

  task automatic arr_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys) begin
      arr_we <= 1'b1;
      arr_addr <= a;
      arr_wdata <= d;
    end
    @(posedge clk_sys) arr_we <= 1'b0;
  endtask : arr_wr

  // array write, command, launch; start flag looked at in the cycle after launch
  task automatic launch(input logic [15:0] a, input logic [7:0] c, input logic exp_go);
    arr_wr(a, 8'h3C);
    wr(`FLC_OFS_CMD, c);
    wr(`FLC_OFS_STAT, 8'h80);
    #1 chk(eng_start, exp_go, "engine start");
    if (exp_go === 1'b1) begin
      chk(eng_cmd, c, "engine command");
      chk(eng_addr, a, "engine address");
      chk(eng_data, 8'h3C, "engine data");
    end
  endtask : launch

  task automatic finish_cmd(input logic blank);
    @(posedge clk_sys) begin
      eng_done <= 1'b1;
      eng_blank <= blank;
    end
    @(posedge clk_sys) eng_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : finish_cmd

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_chk(`FLC_OFS_STAT, 8'hC0, "status after reset");
    rd_chk(`FLC_OFS_PROT, 8'hF0, "protection loaded");
    rd_chk(8'h07, 8'h00, "unmapped read");
    chk(security_state_code, 2'h3, "security after reset");
    $display("test reset done");
  endtask : t_reset

  task automatic t_accerr();
    launch(16'h1000, `FLC_CMD_BYTE, 1'b0);
    rd_chk(`FLC_OFS_STAT, 8'hD0, "no divider error");
    wr(`FLC_OFS_STAT, 8'h00);
    rd_chk(`FLC_OFS_STAT, 8'hD0, "zero write keeps error");
    wr(`FLC_OFS_STAT, 8'h10);
    rd_chk(`FLC_OFS_STAT, 8'hC0, "one write clears error");
    $display("test access error done");
  endtask : t_accerr

  task automatic count_ticks(input int exp);
    int n;
    n = 0;
    repeat (16) @(posedge clk_sys);
    repeat (40) begin
      @(posedge clk_sys);
      #1 if (fclk_tick === 1'b1) n++;
    end
    chk(n[15:0], exp[15:0], "flash tick count");
  endtask : count_ticks

  task automatic t_divider();
    wr(`FLC_OFS_DIV, 8'h03);
    count_ticks(10);
    wr(`FLC_OFS_DIV, 8'h40);
    count_ticks(5);
    $display("test divider done");
  endtask : t_divider

  task automatic t_prot();
    wr(`FLC_OFS_PROT, 8'hF8);
    rd_chk(`FLC_OFS_PROT, 8'hF0, "larger select refused");
    wr(`FLC_OFS_PROT, 8'hE1);
    rd_chk(`FLC_OFS_PROT, 8'hE0, "smaller select taken");
    launch(16'hE200, `FLC_CMD_PAGE, 1'b0);
    rd_chk(`FLC_OFS_STAT, 8'hE0, "violation set");
    wr(`FLC_OFS_STAT, 8'h20);
    rd_chk(`FLC_OFS_STAT, 8'hC0, "violation cleared");
    launch(16'hE000, `FLC_CMD_BYTE, 1'b1);
    finish_cmd(1'b0);
    @(posedge clk_sys) begin
      bdm_prot_we <= 1'b1;
      bdm_prot_wdata <= 8'hF1;
    end
    @(posedge clk_sys) bdm_prot_we <= 1'b0;
    rd_chk(`FLC_OFS_PROT, 8'hF1, "debug write");
    wr(`FLC_OFS_PROT, 8'h10);
    rd_chk(`FLC_OFS_PROT, 8'hF1, "disabled write ignored");
    $display("test protection done");
  endtask : t_prot

  task automatic t_codes();
    logic [7:0] codes [4];
    codes = '{`FLC_CMD_BYTE, `FLC_CMD_BURST, `FLC_CMD_PAGE, `FLC_CMD_MASS};
    foreach (codes[i]) begin
      launch(16'hFE00, codes[i], 1'b1);
      rd_chk(`FLC_OFS_STAT, (codes[i] == `FLC_CMD_BURST) ? 8'h80 : 8'h00, "busy status");
      finish_cmd(1'b0);
      rd_chk(`FLC_OFS_STAT, 8'hC0, "complete status");
    end
    launch(16'h1000, 8'h33, 1'b0);
    rd_chk(`FLC_OFS_STAT, 8'hD0, "illegal code");
    wr(`FLC_OFS_STAT, 8'h50);
    rd_chk(`FLC_OFS_STAT, 8'hC0, "complete bit write ignored");
    $display("test command codes done");
  endtask : t_codes

  task automatic t_blank();
    launch(16'h1000, `FLC_CMD_BLANK, 1'b1);
    finish_cmd(1'b1);
    rd_chk(`FLC_OFS_STAT, 8'hC4, "blank set");
    chk(security_state_code, 2'h2, "security opened");
    wr(`FLC_OFS_STAT, 8'h00);
    rd_chk(`FLC_OFS_STAT, 8'hC4, "blank write ignored");
    launch(16'h1000, `FLC_CMD_BYTE, 1'b1);
    rd_chk(`FLC_OFS_STAT, 8'h00, "blank cleared on launch");
    finish_cmd(1'b0);
    launch(16'h1000, `FLC_CMD_BLANK, 1'b1);
    finish_cmd(1'b0);
    rd_chk(`FLC_OFS_STAT, 8'hC0, "not blank");
    $display("test blank check done");
  endtask : t_blank

  task automatic t_key();
    wr(`FLC_OFS_CFG, 8'h20);
    arr_wr(16'hFFB3, 8'h5A);
    #1 chk({key_we, key_idx}, 4'hB, "key write index");
    chk(key_data, 8'h5A, "key data");
    wr(`FLC_OFS_CMD, `FLC_CMD_BYTE);
    wr(`FLC_OFS_STAT, 8'h80);
    #1 chk(eng_start, 1'b0, "key write starts nothing");
    wr(`FLC_OFS_CFG, 8'h00);
    launch(16'hFFB3, `FLC_CMD_BYTE, 1'b1);
    finish_cmd(1'b0);
    $display("test key select done");
  endtask : t_key

  task automatic stop_pulse(input logic exp);
    @(posedge clk_sys) stop_req <= 1'b1;
    @(posedge clk_sys) stop_req <= 1'b0;
    #1 chk(eng_abort, exp, "stop abort");
    repeat (2) @(posedge clk_sys);
  endtask : stop_pulse

  task automatic t_stop();
    wr(`FLC_OFS_STAT, 8'h10);
    launch(16'h1000, `FLC_CMD_BYTE, 1'b1);
    stop_pulse(1'b1);
    rd_chk(`FLC_OFS_STAT, 8'hD0, "stop during command");
    wr(`FLC_OFS_STAT, 8'h10);
    stop_pulse(1'b0);
    rd_chk(`FLC_OFS_STAT, 8'hC0, "stop while idle");
    $display("test stop done");
  endtask : t_stop

  task automatic t_queue();
    launch(16'hFC00, `FLC_CMD_BURST, 1'b1);
    launch(16'hFC01, `FLC_CMD_BURST, 1'b0);
    rd_chk(`FLC_OFS_STAT, 8'h00, "second burst queued");
    @(posedge clk_sys) eng_done <= 1'b1;
    @(posedge clk_sys) eng_done <= 1'b0;
    #1 chk(eng_start, 1'b1, "queued burst starts");
    chk(eng_addr, 16'hFC01, "queued burst address");
    finish_cmd(1'b0);
    rd_chk(`FLC_OFS_STAT, 8'hC0, "bursts complete");
    $display("test burst queue done");
  endtask : t_queue

  task automatic t_rereset();
    @(posedge clk_sys) begin
      rst_n <= 1'b0;
      nv_prot <= 8'hA1;
      nv_sec <= 2'h1;
    end
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(`FLC_OFS_PROT, 8'hA1, "protection reloaded");
    rd_chk(`FLC_OFS_STAT, 8'hC0, "status after second reset");
    chk(security_state_code, 2'h1, "security reloaded");
    rd_chk(`FLC_OFS_DIV, 8'h00, "divider after second reset");
    $display("test second reset done");
  endtask : t_rereset

  // ==========================================================
  // run control
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // the bench holds no open waits; this only guards against a stalled simulator
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_accerr();
    t_divider();
    t_prot();
    t_codes();
    t_blank();
    t_key();
    t_stop();
    t_queue();
    t_rereset();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
